// ==== mpo_defs.svh ====
// register map, field positions, reset values and timing counts
//
// Function
// - pwm select: code picks which pins carry pwm
// - fixed mode: code bits give levels
// - three writable 12-bit phase compares
// - emergency fall: all outputs float, irq
// - emergency status reads one while active
// - emergency return needs input back high
// - key 5a then a5 before disable
// - no emergency irq while disabled
// - emergency protection enabled from reset
// - overload engages on low input when enabled
// - timer, pwm sync and manual returns
// - overload returns need input back high
// - 200 ns sampling, 1 to 15 lows
// - select which phases overload cuts
// - upper/lower arrangement from prior on-state
// - cut phases go to inactive level
// - no overload irq while disabled
// - manual return wins over synced return
// - optional counter halt during overload
// - separate upper/lower polarity, one is high
`ifndef MPO_DEFS_SVH
`define MPO_DEFS_SVH
// ==========================================
// register indices (byte address is 4x)
`define MPO_IDX_POL 14'h1fae
`define MPO_IDX_EMA 14'h1fb0
`define MPO_IDX_EMB 14'h1fb1
`define MPO_IDX_CFG 14'h1fb2
`define MPO_IDX_CNT 14'h1fb4
`define MPO_IDX_PRD 14'h1fb6
`define MPO_IDX_CMU 14'h1fb8
`define MPO_IDX_CMV 14'h1fba
`define MPO_IDX_CMW 14'h1fbc
`define MPO_IDX_KEY 14'h1fbf
// ==========================================
// fields
`define MPO_POL_UP 5
`define MPO_POL_LO 4
`define MPO_CFG_SEL 8
`define MPO_EMA_CNT 7:4
`define MPO_EMA_ST 2
`define MPO_EMA_RET 1
`define MPO_EMA_EN 0
`define MPO_EMB_MAN 7
`define MPO_EMB_RPWM 6
`define MPO_EMB_RTM 5
`define MPO_EMB_ST 4
`define MPO_EMB_MD 3:2
`define MPO_EMB_HALT 1
`define MPO_EMB_EN 0
`define MPO_KEY_1 8'h5a
`define MPO_KEY_2 8'ha5
// ==========================================
// reset values
`define MPO_RST_EMG_EN 1'b1
`define MPO_RST_OVERLOAD_SAMPLE_COUNT 4'h0
// ==========================================
// timing
`define MPO_CLK_NS 10
`define MPO_SMP_NS 200
`define MPO_CNT_NS 100
`define MPO_SMP_CYC ((`MPO_SMP_NS + `MPO_CLK_NS - 1) / `MPO_CLK_NS)
`define MPO_CNT_CYC ((`MPO_CNT_NS + `MPO_CLK_NS - 1) / `MPO_CLK_NS)
`endif

// ==== mpo_pkg.sv ====
// types shared by the motor pwm output stage
package mpo_pkg;
    // three upper and three lower phase pins
    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } mpo_pins_t;
    typedef enum logic [2:0] {
        KEY_IDLE = 3'b001,
        KEY_HALF = 3'b010,
        KEY_OPEN = 3'b100
    } mpo_key_t;
    typedef enum logic [1:0] {
        CUT_NONE = 2'h0,
        CUT_ALL = 2'h1,
        CUT_PWM = 2'h2,
        CUT_SPLIT = 2'h3
    } mpo_cut_t;
endpackage

// ==== mpo_top.sv ====
// motor pwm output stage with emergency and overload protection
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mpo_defs.svh"
module mpo_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // protection pins, both active low
    input wire logic emergency_stop_n,
    input wire logic overload_n,
    // timer 1 sync pulse from on-chip timer
    input wire logic timer1_sync,
    // phase pins
    output mpo_pkg::mpo_pins_t phase_out,
    output mpo_pkg::mpo_pins_t phase_oe_n,
    // event pulses
    output logic emergency_irq,
    output logic overload_irq
);
    localparam int SMP_CYC = `MPO_SMP_CYC;
    localparam int CNT_CYC = `MPO_CNT_CYC;

    // ==========================================
    // bus slave
    logic aph_wr_q;
    logic [13:0] aph_idx_q;
    logic [31:0] rdata_q;
    logic take;
    logic [13:0] idx;
    logic wr_cfg, wr_ema, wr_emb, wr_key, wr_prd;
    logic wr_cmu, wr_cmv, wr_cmw, wr_pol;
    // register state
    logic [10:0] output_config_q;
    logic [11:0] period_q;
    logic [11:0] cmp_q [3];
    logic [11:0] cnt_q;
    logic upper_pol_q, lower_pol_q;
    logic emg_en_q;
    logic [3:0] overload_sample_count_q;
    logic overload_enable_q, halt_q, overload_return_pwm_sync_q, rttm_q;
    mpo_pkg::mpo_cut_t cut_q;
    mpo_pkg::mpo_key_t key_q;
    logic emg_q, ovl_q;

    assign take = hsel & hready & htrans[1];
    assign idx = (haddr[31:16] == 16'h0000) ? haddr[15:2] : 14'h0000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_wr_q <= 1'b0;
            aph_idx_q <= 14'h0000;
        end else begin
            aph_wr_q <= take & hwrite;
            aph_idx_q <= idx;
        end
    end

    assign wr_pol = aph_wr_q && aph_idx_q == `MPO_IDX_POL;
    assign wr_ema = aph_wr_q && aph_idx_q == `MPO_IDX_EMA;
    assign wr_emb = aph_wr_q && aph_idx_q == `MPO_IDX_EMB;
    assign wr_cfg = aph_wr_q && aph_idx_q == `MPO_IDX_CFG;
    assign wr_prd = aph_wr_q && aph_idx_q == `MPO_IDX_PRD;
    assign wr_cmu = aph_wr_q && aph_idx_q == `MPO_IDX_CMU;
    assign wr_cmv = aph_wr_q && aph_idx_q == `MPO_IDX_CMV;
    assign wr_cmw = aph_wr_q && aph_idx_q == `MPO_IDX_CMW;
    assign wr_key = aph_wr_q && aph_idx_q == `MPO_IDX_KEY;

    // read data sampled in the address phase; the key reads as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0;
        end else if (take && !hwrite) begin
            rdata_q <= 32'h0;
            case (idx)
                `MPO_IDX_POL: begin
                    rdata_q[`MPO_POL_UP] <= upper_pol_q;
                    rdata_q[`MPO_POL_LO] <= lower_pol_q;
                end
                `MPO_IDX_EMA: begin
                    rdata_q[`MPO_EMA_CNT] <= overload_sample_count_q;
                    rdata_q[`MPO_EMA_ST] <= emg_q;
                    rdata_q[`MPO_EMA_EN] <= emg_en_q;
                end
                `MPO_IDX_EMB: begin
                    rdata_q[`MPO_EMB_MAN] <= ovl_q;
                    rdata_q[`MPO_EMB_RPWM] <= overload_return_pwm_sync_q;
                    rdata_q[`MPO_EMB_RTM] <= rttm_q;
                    rdata_q[`MPO_EMB_ST] <= ovl_q;
                    rdata_q[`MPO_EMB_MD] <= cut_q;
                    rdata_q[`MPO_EMB_HALT] <= halt_q;
                    rdata_q[`MPO_EMB_EN] <= overload_enable_q;
                end
                `MPO_IDX_CFG: rdata_q[10:0] <= output_config_q;
                `MPO_IDX_CNT: rdata_q[11:0] <= cnt_q;
                `MPO_IDX_PRD: rdata_q[11:0] <= period_q;
                `MPO_IDX_CMU: rdata_q[11:0] <= cmp_q[0];
                `MPO_IDX_CMV: rdata_q[11:0] <= cmp_q[1];
                `MPO_IDX_CMW: rdata_q[11:0] <= cmp_q[2];
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    // ==========================================
    // plain control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_config_q <= 11'h000;
            period_q <= 12'h000;
            cmp_q[0] <= 12'h000;
            cmp_q[1] <= 12'h000;
            cmp_q[2] <= 12'h000;
            upper_pol_q <= 1'b0;
            lower_pol_q <= 1'b0;
            overload_sample_count_q <= `MPO_RST_OVERLOAD_SAMPLE_COUNT;
            overload_enable_q <= 1'b0;
            halt_q <= 1'b0;
            overload_return_pwm_sync_q <= 1'b0;
            rttm_q <= 1'b0;
            cut_q <= mpo_pkg::CUT_NONE;
        end else begin
            if (wr_cfg)
                output_config_q <= hwdata[10:0];
            if (wr_prd)
                period_q <= hwdata[11:0];
            if (wr_cmu)
                cmp_q[0] <= hwdata[11:0];
            if (wr_cmv)
                cmp_q[1] <= hwdata[11:0];
            if (wr_cmw)
                cmp_q[2] <= hwdata[11:0];
            if (wr_pol) begin
                upper_pol_q <= hwdata[`MPO_POL_UP];
                lower_pol_q <= hwdata[`MPO_POL_LO];
            end
            if (wr_ema)
                overload_sample_count_q <= hwdata[`MPO_EMA_CNT];
            if (wr_emb) begin
                overload_return_pwm_sync_q <= hwdata[`MPO_EMB_RPWM];
                rttm_q <= hwdata[`MPO_EMB_RTM];
                cut_q <= mpo_pkg::mpo_cut_t'(hwdata[`MPO_EMB_MD]);
                halt_q <= hwdata[`MPO_EMB_HALT];
                overload_enable_q <= hwdata[`MPO_EMB_EN];
            end
        end
    end

    // ==========================================
    // key lock and emergency enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key_q <= mpo_pkg::KEY_IDLE;
            emg_en_q <= `MPO_RST_EMG_EN;
        end else begin
            // two-byte unlock, any other byte relocks
            if (wr_key) begin
                case (key_q)
                    mpo_pkg::KEY_IDLE:
                        key_q <= (hwdata[7:0] == `MPO_KEY_1) ?
                            mpo_pkg::KEY_HALF : mpo_pkg::KEY_IDLE;
                    mpo_pkg::KEY_HALF:
                        key_q <= (hwdata[7:0] == `MPO_KEY_2) ?
                            mpo_pkg::KEY_OPEN : mpo_pkg::KEY_IDLE;
                    default: key_q <= mpo_pkg::KEY_IDLE;
                endcase
            end else if (wr_ema) begin
                key_q <= mpo_pkg::KEY_IDLE;
                if (hwdata[`MPO_EMA_EN])
                    emg_en_q <= 1'b1;
                else if (key_q == mpo_pkg::KEY_OPEN)
                    emg_en_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // input synchronisers
    logic emg_s1, emg_s2, emg_s3, ovl_s1, ovl_s2;
    logic emg_fall;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            emg_s1 <= 1'b1;
            emg_s2 <= 1'b1;
            emg_s3 <= 1'b1;
            ovl_s1 <= 1'b1;
            ovl_s2 <= 1'b1;
        end else begin
            emg_s1 <= emergency_stop_n;
            emg_s2 <= emg_s1;
            emg_s3 <= emg_s2;
            ovl_s1 <= overload_n;
            ovl_s2 <= ovl_s1;
        end
    end
    assign emg_fall = emg_s3 & ~emg_s2;

    // ==========================================
    // rate enables
    logic [4:0] smp_div_q;
    logic [3:0] cnt_div_q;
    logic smp_tick, cnt_tick;
    assign smp_tick = smp_div_q == 5'(SMP_CYC - 1);
    assign cnt_tick = cnt_div_q == 4'(CNT_CYC - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smp_div_q <= 5'h00;
            cnt_div_q <= 4'h0;
        end else begin
            smp_div_q <= smp_tick ? 5'h00 : smp_div_q + 5'h01;
            cnt_div_q <= cnt_tick ? 4'h0 : cnt_div_q + 4'h1;
        end
    end

    // ==========================================
    // pwm counter (sawtooth)
    logic run, wrap;
    logic [2:0] pwm;
    assign run = cnt_tick & ~(halt_q & ovl_q);
    assign wrap = run & (cnt_q >= period_q);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            cnt_q <= 12'h000;
        else if (run)
            cnt_q <= wrap ? 12'h000 : cnt_q + 12'h001;
    end
    always_comb begin
        for (int i = 0; i < 3; i++)
            pwm[i] = cnt_q < cmp_q[i];
    end

    // ==========================================
    // emergency protection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            emg_q <= 1'b0;
            emergency_irq <= 1'b0;
        end else begin
            emergency_irq <= emg_en_q & emg_fall;
            if (emg_en_q && emg_fall)
                emg_q <= 1'b1;
            // return only once input is high
            else if (emg_q && wr_ema && hwdata[`MPO_EMA_RET] && emg_s2)
                emg_q <= 1'b0;
        end
    end

    // ==========================================
    // overload protection
    logic [3:0] low_cnt_q;
    logic [3:0] need;
    logic [2:0] snap_u_q, snap_l_q;
    logic [2:0] act_u, act_l;
    logic man_ret;
    assign need = (overload_sample_count_q == 4'h0) ? 4'h1 : overload_sample_count_q;
    assign man_ret = wr_emb & hwdata[`MPO_EMB_MAN];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovl_q <= 1'b0;
            overload_irq <= 1'b0;
            low_cnt_q <= 4'h0;
            snap_u_q <= 3'h0;
            snap_l_q <= 3'h0;
        end else begin
            overload_irq <= 1'b0;
            // disabled means no state and no irq
            if (!overload_enable_q) begin
                ovl_q <= 1'b0;
                low_cnt_q <= 4'h0;
            end else if (!ovl_q) begin
                if (smp_tick && !ovl_s2) begin
                    if (({1'b0, low_cnt_q} + 5'h01) >= {1'b0, need}) begin
                        ovl_q <= 1'b1;
                        overload_irq <= 1'b1;
                        low_cnt_q <= 4'h0;
                        snap_u_q <= act_u;
                        snap_l_q <= act_l;
                    end else begin
                        low_cnt_q <= low_cnt_q + 4'h1;
                    end
                end else if (smp_tick) begin
                    low_cnt_q <= 4'h0;
                end
            end else if (ovl_s2) begin
                // manual first, then pwm, then timer
                if (man_ret)
                    ovl_q <= 1'b0;
                else if (overload_return_pwm_sync_q && wrap)
                    ovl_q <= 1'b0;
                else if (rttm_q && timer1_sync)
                    ovl_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // output mapping
    logic [2:0] out_u, out_l;
    logic up2, lo2;
    assign up2 = (snap_u_q[0] & snap_u_q[1]) | (snap_u_q[0] & snap_u_q[2])
        | (snap_u_q[1] & snap_u_q[2]);
    assign lo2 = (snap_l_q[0] & snap_l_q[1]) | (snap_l_q[0] & snap_l_q[2])
        | (snap_l_q[1] & snap_l_q[2]);
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (output_config_q[`MPO_CFG_SEL + i]) begin
                act_u[i] = (output_config_q[2*i +: 2] == 2'b01) ?
                    1'b0 : pwm[i];
                act_l[i] = (output_config_q[2*i +: 2] == 2'b10) ?
                    1'b0 : ~pwm[i];
            end else begin
                act_u[i] = output_config_q[2*i + 1];
                act_l[i] = output_config_q[2*i];
            end
        end
        out_u = act_u;
        out_l = act_l;
        if (ovl_q) begin
            case (cut_q)
                mpo_pkg::CUT_ALL: begin
                    out_u = 3'h0;
                    out_l = 3'h0;
                end
                mpo_pkg::CUT_PWM: begin
                    out_u = act_u & ~output_config_q[10:8];
                    out_l = act_l & ~output_config_q[10:8];
                end
                // side that was mostly on stays on
                mpo_pkg::CUT_SPLIT: begin
                    out_u = up2 ? 3'h7 : 3'h0;
                    out_l = (!up2 && lo2) ? 3'h7 : 3'h0;
                end
                default: begin
                    out_u = act_u;
                    out_l = act_l;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_out <= '0;
            phase_oe_n <= '0;
        end else begin
            // zero polarity bit means active low
            phase_out.upper <= out_u ^ {3{~upper_pol_q}};
            phase_out.lower <= out_l ^ {3{~lower_pol_q}};
            // all six float while in emergency
            phase_oe_n <= {6{emg_q}};
        end
    end

    // ==========================================
    // checks
    emg_float_a: assert property (@(posedge hclk) disable iff (!hresetn)
        emg_en_q && emg_fall |=> ##1 (phase_oe_n == 6'h3f) && emg_q)
        else $error("outputs not floated after emergency edge");
    emg_stat_a: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && idx == `MPO_IDX_EMA
        |=> hrdata[`MPO_EMA_ST] == $past(emg_q))
        else $error("emergency status misread");
    emg_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        emg_q && !emg_s2 |=> emg_q)
        else $error("emergency left while input low");
    key_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(emg_en_q) |-> $past(key_q) == mpo_pkg::KEY_OPEN)
        else $error("emergency disabled without key");
    emg_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !emg_en_q |=> !emergency_irq)
        else $error("emergency irq while disabled");
    ovl_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !overload_enable_q |=> !overload_irq && !ovl_q)
        else $error("overload irq while disabled");
    ovl_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ovl_q && overload_enable_q && !ovl_s2 |=> ovl_q)
        else $error("overload left while input low");
    ovl_cut_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ovl_q && cut_q == mpo_pkg::CUT_ALL
        |=> phase_out.upper == {3{~$past(upper_pol_q)}})
        else $error("cut upper phase not inactive");
    cnt_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ovl_q && halt_q |=> $stable(cnt_q))
        else $error("counter ran while halted");
    man_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ovl_q && overload_enable_q && ovl_s2 && man_ret |=> !ovl_q)
        else $error("manual return not taken");
endmodule
`default_nettype wire

// ==== mpo_stage.sv ====
// power stage and fault inputs model for the motor pwm output stage
`timescale 1ns/1ps
`default_nettype none
module mpo_stage (
    // clock
    input wire logic hclk,
    // fault requests from the bench
    input wire logic emg_fault,
    input wire logic ovl_fault,
    // phase pins from the output stage
    input wire mpo_pkg::mpo_pins_t phase_out,
    input wire mpo_pkg::mpo_pins_t phase_oe_n,
    // fault lines, active low, and levels at the bridge
    output logic emergency_stop_n,
    output logic overload_n,
    output mpo_pkg::mpo_pins_t bridge
);
    // ==========================================
    // fault lines
    // lines are registered and change on a rising edge
    always_ff @(posedge hclk) begin
        emergency_stop_n <= !emg_fault;
        overload_n <= !ovl_fault;
    end
    // ==========================================
    // bridge inputs
    // no pull on the gate inputs: a floated pin toggles every cycle
    always_ff @(posedge hclk) begin
        for (int i = 0; i < 6; i++) begin
            if (phase_oe_n[i] == 1'b0) begin
                bridge[i] <= phase_out[i];
            end else begin
                bridge[i] <= !bridge[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== mpo_top_test.sv ====
// self-checking bench for the motor pwm output stage
`timescale 1ns/1ps
`default_nettype none
`include "mpo_defs.svh"
module mpo_top_test;
    // ==========================================
    // signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp;
    logic [31:0] hrdata, rdv;
    logic emergency_stop_n, overload_n, emergency_irq, overload_irq;
    logic emg_fault = 1'b0;
    logic ovl_fault = 1'b0;
    logic timer1_sync = 1'b0;
    mpo_pkg::mpo_pins_t phase_out, phase_oe_n, bridge;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int got;

    assign hready = hreadyout;
    always #5 hclk = ~hclk;

    mpo_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .emergency_stop_n,
        .overload_n, .timer1_sync, .phase_out, .phase_oe_n, .emergency_irq,
        .overload_irq);
    mpo_stage stage (.hclk, .emg_fault, .ovl_fault, .phase_out, .phase_oe_n,
        .emergency_stop_n, .overload_n, .bridge);

    // ==========================================
    // tasks
    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one single word transfer; read data lands in rdv
    task automatic bus(input logic [13:0] idx, input logic w,
        input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {16'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rd(input string what, input logic [13:0] idx,
        input logic [31:0] exp);
        bus(idx, 1'b0, 32'h0);
        check(what, rdv, exp);
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    // pins are registered: let the new setting reach them first
    task automatic pins(input string what, input logic [5:0] exp);
        repeat (3) @(posedge hclk);
        #1;
        check(what, {26'h0, phase_out}, {26'h0, exp});
        check("bridge", {26'h0, bridge}, {26'h0, exp});
    endtask

    task automatic fault(input logic e, input logic o);
        @(posedge hclk);
        emg_fault <= e;
        ovl_fault <= o;
    endtask

    task automatic tick_timer();
        @(posedge hclk);
        timer1_sync <= 1'b1;
        @(posedge hclk);
        timer1_sync <= 1'b0;
    endtask

    // got is the cycle the pulse came in, or -1
    task automatic watch(input logic ovl, input int lim);
        got = -1;
        for (int i = 1; i <= lim && got < 0; i++) begin
            @(posedge hclk);
            #1;
            if ((ovl ? overload_irq : emergency_irq) === 1'b1) got = i;
        end
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            finish_test();
        end
    end

    // ==========================================
    // sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd("ctrl_a", `MPO_IDX_EMA, 32'h1);
        pins("rst_pins", 6'h3f);
        wr(`MPO_IDX_CFG, 32'h39);
        wr(`MPO_IDX_POL, 32'h30);
        pins("fixed_hi", 6'b110_101);
        wr(`MPO_IDX_POL, 32'h0);
        pins("fixed_lo", 6'b001_010);
        wr(`MPO_IDX_POL, 32'h20);
        pins("fixed_mix", 6'b110_010);
        for (int i = 0; i < 3; i++) begin
            wr(`MPO_IDX_CMU + 14'(2 * i), 32'hffff_fa50 + i);
            rd("compare", `MPO_IDX_CMU + 14'(2 * i), 32'ha50 + i);
        end
        wr(`MPO_IDX_PRD, 32'h10);
        wr(`MPO_IDX_POL, 32'h30);
        wr(`MPO_IDX_CFG, 32'h724);
        pins("pwm_full", 6'b101_000);
        for (int i = 0; i < 3; i++) wr(`MPO_IDX_CMU + 14'(2 * i), 32'h0);
        wr(`MPO_IDX_CFG, 32'h727);
        pins("pwm_zero", 6'b000_011);
        // emergency stop and return
        wr(`MPO_IDX_CFG, 32'h3f);
        fault(1'b1, 1'b0);
        watch(1'b0, 20);
        check("emg_irq", 32'(got > 0), 32'h1);
        repeat (2) @(posedge hclk);
        check("float", {26'h0, phase_oe_n}, 32'h3f);
        rd("emg_state", `MPO_IDX_EMA, 32'h5);
        wr(`MPO_IDX_EMA, 32'h3);
        rd("emg_hold", `MPO_IDX_EMA, 32'h5);
        fault(1'b0, 1'b0);
        wr(`MPO_IDX_CFG, 32'h0);
        wr(`MPO_IDX_EMA, 32'h3);
        rd("emg_ret", `MPO_IDX_EMA, 32'h1);
        check("drive", {26'h0, phase_oe_n}, 32'h0);
        // key sequence, wrong then right
        wr(`MPO_IDX_KEY, 32'h5a);
        wr(`MPO_IDX_KEY, 32'h12);
        wr(`MPO_IDX_EMA, 32'h0);
        rd("key_bad", `MPO_IDX_EMA, 32'h1);
        wr(`MPO_IDX_KEY, 32'h5a);
        wr(`MPO_IDX_KEY, 32'ha5);
        wr(`MPO_IDX_EMA, 32'h0);
        rd("key_ok", `MPO_IDX_EMA, 32'h0);
        fault(1'b1, 1'b0);
        watch(1'b0, 20);
        check("emg_off", 32'(got), 32'hffff_ffff);
        fault(1'b0, 1'b0);
        repeat (4) @(posedge hclk);
        // overload: three lows, all phases cut
        wr(`MPO_IDX_CFG, 32'h3f);
        wr(`MPO_IDX_EMA, 32'h31);
        wr(`MPO_IDX_EMB, 32'h05);
        fault(1'b0, 1'b1);
        watch(1'b1, 38);
        check("ovl_early", 32'(got), 32'hffff_ffff);
        watch(1'b1, 80);
        check("ovl_irq", 32'(got > 0), 32'h1);
        pins("ovl_cut", 6'h0);
        rd("ovl_state", `MPO_IDX_EMB, 32'h95);
        wr(`MPO_IDX_EMB, 32'h85);
        pins("ovl_hold", 6'h0);
        fault(1'b0, 1'b0);
        repeat (4) @(posedge hclk);
        wr(`MPO_IDX_EMB, 32'hc5);
        pins("man_ret", 6'h3f);
        // split cut from the prior on-state, timer return
        wr(`MPO_IDX_CFG, 32'h1a);
        wr(`MPO_IDX_EMB, 32'h2d);
        fault(1'b0, 1'b1);
        watch(1'b1, 120);
        pins("split", 6'b111_000);
        tick_timer();
        pins("tmr_hold", 6'b111_000);
        fault(1'b0, 1'b0);
        repeat (6) @(posedge hclk);
        tick_timer();
        pins("tmr_ret", 6'b011_100);
        // pwm phase cut with counter halt, then pwm sync return
        wr(`MPO_IDX_CMU, 32'hfff);
        wr(`MPO_IDX_CFG, 32'h11a);
        wr(`MPO_IDX_EMB, 32'h4b);
        fault(1'b0, 1'b1);
        watch(1'b1, 120);
        pins("cut_pwm", 6'b010_100);
        bus(`MPO_IDX_CNT, 1'b0, 32'h0);
        got = rdv;
        repeat (30) @(posedge hclk);
        rd("halt", `MPO_IDX_CNT, 32'(got));
        fault(1'b0, 1'b0);
        repeat (6) @(posedge hclk);
        wr(`MPO_IDX_EMB, 32'h49);
        pins("pwm_wait", 6'b010_100);
        repeat (200) @(posedge hclk);
        pins("pwm_ret", 6'b011_100);
        // overload disabled: no pulse, no cut
        wr(`MPO_IDX_EMB, 32'h04);
        fault(1'b0, 1'b1);
        watch(1'b1, 100);
        check("ovl_off", 32'(got), 32'hffff_ffff);
        pins("ovl_off_pins", 6'b011_100);
        finish_test();
    end
endmodule
`default_nettype wire
